/* sdw_pkg.sv */
// package: register map, reset values and timing for the dual watchdog
package sdw_pkg;
  localparam logic [15:0] SDW_OFS_DIVIDER = 16'h0400;
  localparam logic [15:0] SDW_OFS_LPI_TIMER = 16'h0410;
  localparam logic [15:0] SDW_OFS_SC_TIMER = 16'h0420;
  localparam logic [15:0] SDW_RST_DIVIDER = 16'h09C2;
  localparam logic [15:0] SDW_RST_SC_TIMER = 16'h03E8;
  localparam logic [15:0] SDW_RST_LPI_TIMER = 16'h03E8;
  localparam logic [15:0] SDW_DIV_EXTRA = 16'h0002;
  // base tick period and core clock, both in ns
  localparam int SDW_BASE_TICK_NS = 40;
  localparam int SDW_CLK_NS = 4;
  localparam int SDW_BASE_CYC = SDW_BASE_TICK_NS / SDW_CLK_NS;
  localparam logic [3:0] SDW_BASE_LAST = 4'(SDW_BASE_CYC - 1);
  localparam int SDW_NUM_DOGS = 2;
  localparam int SDW_DOG_SC = 0;
  localparam int SDW_DOG_LPI = 1;
endpackage

/* sdw_regfile.sv */
// register file: divider and two timers, registered read data
`timescale 1ns/1ps
module sdw_regfile (
  input wire logic clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic wr_en, // register write strobe
  input wire logic rd_en, // register read strobe
  input wire logic [15:0] addr, // register offset
  input wire logic [15:0] wdata, // write data
  output logic [15:0] rdata_q, // registered read data
  output logic [15:0] divider_q, // tick divider value
  output logic [15:0] lpi_timer_q, // local interface timer
  output logic [15:0] sc_timer_q // sync channel timer
);
  logic [15:0] rdata_d;
  logic [15:0] divider_d;
  logic [15:0] lpi_timer_d;
  logic [15:0] sc_timer_d;

  // writes and read-back decode; unmapped reads give zero
  always_comb
  begin
    divider_d = divider_q;
    lpi_timer_d = lpi_timer_q;
    sc_timer_d = sc_timer_q;
    rdata_d = rdata_q;
    if (wr_en)
    begin
      case (addr)
        sdw_pkg::SDW_OFS_DIVIDER: divider_d = wdata;
        sdw_pkg::SDW_OFS_LPI_TIMER: lpi_timer_d = wdata;
        sdw_pkg::SDW_OFS_SC_TIMER: sc_timer_d = wdata;
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (addr)
        sdw_pkg::SDW_OFS_DIVIDER: rdata_d = divider_q;
        sdw_pkg::SDW_OFS_LPI_TIMER: rdata_d = lpi_timer_q;
        sdw_pkg::SDW_OFS_SC_TIMER: rdata_d = sc_timer_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // register stage, defaults give 100 ms on both dogs
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      divider_q <= sdw_pkg::SDW_RST_DIVIDER;
      lpi_timer_q <= sdw_pkg::SDW_RST_LPI_TIMER;
      sc_timer_q <= sdw_pkg::SDW_RST_SC_TIMER;
      rdata_q <= 16'h0000;
    end
    else if (ce)
    begin
      divider_q <= divider_d;
      lpi_timer_q <= lpi_timer_d;
      sc_timer_q <= sc_timer_d;
      rdata_q <= rdata_d;
    end
  end
endmodule

/* sdw_watchdog.sv */
// dual communication watchdog of the slave controller
// Summary of operation
// - one shared divider register at 0x0400
// - own timers: 0x0420 sync, 0x0410 local
// - timeout = 40ns * (divider+2) * timer
// - watchdog tick = divider+2 base ticks
// - defaults 2498 and 1000: 100 ms
// - process-data exchange restarts sync watchdog
// - enabled sync watchdog expires without exchange
// - expiry leaves network state untouched
// - sync expiry held until next exchange, or until disabled (enable low or timer zero)
// - local watchdog expires without processor access
// - expiry drives outputs to preset safe state
// - sync timer zero disables that watchdog
// - settings readable back at their offsets
// - sync timeout reaches about 170 seconds
// - safe-operational holds outputs safe, inputs live
`timescale 1ns/1ps
module sdw_watchdog #(
  parameter int OUT_W = 8 // width of the guarded output image
) (
  input wire logic clk, // core clock, 250 MHz
  input wire logic nrst, // sync reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [15:0] reg_addr, // register offset
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic sc_enable, // sync channel watchdog enabled
  input wire logic lpi_enable, // local interface watchdog enabled
  input wire logic pd_exchange, // successful process-data pulse
  input wire logic lpi_access, // local processor access pulse
  input wire logic safe_op_state, // in safe-operational state
  input wire logic [OUT_W-1:0] out_data, // output image from master
  input wire logic [OUT_W-1:0] safe_value, // preset safe value
  input wire logic safe_use_value, // 1: safe value, 0: all off
  output logic [15:0] reg_rdata_q, // register read data
  output logic sc_expired_q, // sync channel watchdog expired
  output logic lpi_expired_q, // local interface watchdog expired
  output logic [OUT_W-1:0] out_pins_q // outputs to the process
);
  logic [15:0] divider;
  logic [15:0] lpi_timer;
  logic [15:0] sc_timer;
  logic [3:0] base_cnt_q;
  logic [3:0] base_cnt_d;
  // one bit above the divider: divider+2 base ticks reach 65537 (~2.6 ms)
  logic [16:0] tick_cnt_q;
  logic [16:0] tick_cnt_d;
  logic tick;
  logic [15:0] cnt_q [sdw_pkg::SDW_NUM_DOGS];
  logic [15:0] cnt_d [sdw_pkg::SDW_NUM_DOGS];
  logic exp_d [sdw_pkg::SDW_NUM_DOGS];
  logic exp_q [sdw_pkg::SDW_NUM_DOGS];
  logic [OUT_W-1:0] out_d;
  logic safe;

  // divider+2 base ticks form one watchdog tick
  function automatic logic [16:0] sdw_tick_last(input logic [15:0] div);
    sdw_tick_last = {1'b0, div} + {1'b0, sdw_pkg::SDW_DIV_EXTRA} - 17'h00001;
  endfunction

  sdw_regfile u_regs (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .wr_en(reg_wr),
    .rd_en(reg_rd),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .rdata_q(reg_rdata_q),
    .divider_q(divider),
    .lpi_timer_q(lpi_timer),
    .sc_timer_q(sc_timer)
  );

  // shared prescaler: 40 ns base tick, then divider+2 of them
  always_comb
  begin
    base_cnt_d = base_cnt_q + 4'h1;
    tick_cnt_d = tick_cnt_q;
    tick = 1'b0;
    if (base_cnt_q == sdw_pkg::SDW_BASE_LAST)
    begin
      base_cnt_d = 4'h0;
      if (tick_cnt_q >= sdw_tick_last(divider))
      begin
        tick_cnt_d = 17'h00000;
        tick = 1'b1;
      end
      else
        tick_cnt_d = tick_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      base_cnt_q <= 4'h0;
      tick_cnt_q <= 17'h00000;
    end
    else if (ce)
    begin
      base_cnt_q <= base_cnt_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // down-counters: reload on activity, expire at zero; 16-bit ticks
  // of up to 65537*40ns allow about 170 s on the sync channel
  always_comb
  begin
    logic [15:0] rld [sdw_pkg::SDW_NUM_DOGS];
    logic hit [sdw_pkg::SDW_NUM_DOGS];
    logic en [sdw_pkg::SDW_NUM_DOGS];
    rld[sdw_pkg::SDW_DOG_SC] = sc_timer;
    rld[sdw_pkg::SDW_DOG_LPI] = lpi_timer;
    hit[sdw_pkg::SDW_DOG_SC] = pd_exchange;
    hit[sdw_pkg::SDW_DOG_LPI] = lpi_access;
    // timer zero switches the dog off entirely
    en[sdw_pkg::SDW_DOG_SC] = sc_enable && (sc_timer != 16'h0000);
    en[sdw_pkg::SDW_DOG_LPI] = lpi_enable && (lpi_timer != 16'h0000);
    for (int i = 0; i < sdw_pkg::SDW_NUM_DOGS; i++)
    begin
      cnt_d[i] = cnt_q[i];
      exp_d[i] = exp_q[i];
      if (!en[i])
      begin
        cnt_d[i] = rld[i];
        exp_d[i] = 1'b0;
      end
      else if (hit[i])
      begin
        cnt_d[i] = rld[i];
        exp_d[i] = 1'b0;
      end
      else if (tick && cnt_q[i] != 16'h0000)
      begin
        cnt_d[i] = cnt_q[i] - 16'h0001;
        if (cnt_q[i] == 16'h0001)
          exp_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      // start from the default timers so an idle enabled dog still expires
      cnt_q[sdw_pkg::SDW_DOG_SC] <= sdw_pkg::SDW_RST_SC_TIMER;
      cnt_q[sdw_pkg::SDW_DOG_LPI] <= sdw_pkg::SDW_RST_LPI_TIMER;
      for (int i = 0; i < sdw_pkg::SDW_NUM_DOGS; i++)
      begin
        exp_q[i] <= 1'b0;
      end
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  // output stage; network state is not ours to change on expiry
  assign safe = exp_d[sdw_pkg::SDW_DOG_SC] || exp_d[sdw_pkg::SDW_DOG_LPI]
    || safe_op_state;
  always_comb
  begin
    out_d = out_data;
    if (safe)
      out_d = safe_use_value ? safe_value : '0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_pins_q <= '0;
      sc_expired_q <= 1'b0;
      lpi_expired_q <= 1'b0;
    end
    else if (ce)
    begin
      out_pins_q <= out_d;
      sc_expired_q <= exp_d[sdw_pkg::SDW_DOG_SC];
      lpi_expired_q <= exp_d[sdw_pkg::SDW_DOG_LPI];
    end
  end

  // assertions
  sequence s_exchange;
    ce && pd_exchange;
  endsequence

  rst_div_a: assert property (@(posedge clk)
    $fell(nrst) |=> divider == sdw_pkg::SDW_RST_DIVIDER
      && sc_timer == sdw_pkg::SDW_RST_SC_TIMER)
    else $error("reset defaults wrong");

  sc_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    s_exchange |=> !sc_expired_q)
    else $error("sync expiry not cleared by exchange");

  sc_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && sc_timer == 16'h0000 |=> !sc_expired_q)
    else $error("zero timer still expired");

  sc_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && sc_expired_q && sc_enable && sc_timer != 16'h0000 && !pd_exchange
    |=> sc_expired_q)
    else $error("sync expiry dropped without exchange");

  lpi_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && lpi_access |=> !lpi_expired_q)
    else $error("local expiry not cleared by access");

  safe_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (sc_expired_q || lpi_expired_q) && !safe_use_value
    && $stable(safe_use_value)
    |-> out_pins_q == '0)
    else $error("outputs not off on expiry");

  no_early_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(sc_expired_q) |-> $past(cnt_q[sdw_pkg::SDW_DOG_SC]) == 16'h0001)
    else $error("expiry before count reached zero");

  tick_gap_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && tick |=> !tick)
    else $error("watchdog ticks back to back");

  rd_back_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && reg_addr == sdw_pkg::SDW_OFS_SC_TIMER && !reg_wr
    |=> reg_rdata_q == $past(sc_timer))
    else $error("sync timer read-back wrong");

  sc_reload_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && pd_exchange && sc_enable && sc_timer != 16'h0000
    |=> cnt_q[sdw_pkg::SDW_DOG_SC] == $past(sc_timer))
    else $error("sync count not reloaded by exchange");

  safe_state_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && safe_op_state && safe_use_value |=> out_pins_q == $past(safe_value))
    else $error("outputs not safe in safe-operational");
endmodule

/* sdw_partner.sv */
// partner model: network master and local processor activity
`timescale 1ns/1ps
module sdw_partner (
  input wire logic clk, // core clock
  input wire logic run_pd, // master keeps exchanging process data
  input wire logic run_lpi, // local processor keeps accessing
  output logic pd_exchange, // exchange pulse
  output logic lpi_access // access pulse
);
  logic [3:0] cnt_q;
  // pulses each 16 clocks, well inside the shortest timeout used
  always @(negedge clk)
  begin
    cnt_q <= cnt_q + 4'h1;
    pd_exchange <= run_pd && (cnt_q == 4'hF);
    lpi_access <= run_lpi && (cnt_q == 4'hF);
  end
  // quiet start, no activity until asked
  initial
  begin
    cnt_q = 4'h0;
    pd_exchange = 1'b0;
    lpi_access = 1'b0;
  end
endmodule

/* sdw_watchdog_tb.sv */
// self-checking bench of the dual watchdog
`timescale 1ns/1ps
`define CHK(a, b) check_val(32'(a), 32'(b))
module sdw_watchdog_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic sc_enable = 1'b0;
  logic lpi_enable = 1'b0;
  logic tb_pd = 1'b0;
  logic tb_lpi = 1'b0;
  logic run_pd = 1'b0;
  logic run_lpi = 1'b0;
  logic safe_op_state = 1'b0;
  logic [7:0] out_data = 8'hA5;
  logic [7:0] safe_value = 8'h3C;
  logic safe_use_value = 1'b1;
  logic p_pd;
  logic p_lpi;
  logic [15:0] reg_rdata_q;
  logic sc_expired_q;
  logic lpi_expired_q;
  logic [7:0] out_pins_q;
  int err_count = 0;
  int compares = 0;
  // 250 MHz core clock
  always #2 clk = ~clk;
  sdw_watchdog #(.OUT_W(8)) dut (.clk(clk), .nrst(nrst), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .sc_enable(sc_enable), .lpi_enable(lpi_enable),
    .pd_exchange(tb_pd | p_pd), .lpi_access(tb_lpi | p_lpi),
    .safe_op_state(safe_op_state), .out_data(out_data),
    .safe_value(safe_value), .safe_use_value(safe_use_value),
    .reg_rdata_q(reg_rdata_q), .sc_expired_q(sc_expired_q),
    .lpi_expired_q(lpi_expired_q), .out_pins_q(out_pins_q));
  sdw_partner partner (.clk(clk), .run_pd(run_pd), .run_lpi(run_lpi),
    .pd_exchange(p_pd), .lpi_access(p_lpi));
  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK(reg_rdata_q, exp);
  endtask
  // one-cycle activity pulse, sel 0 sync channel, 1 local processor
  task automatic pulse(input bit sel);
    @(negedge clk);
    if (sel) tb_lpi = 1'b1;
    else tb_pd = 1'b1;
    @(negedge clk);
    tb_lpi = 1'b0;
    tb_pd = 1'b0;
  endtask
  // bounded wait for an expiry flag; running out ends the run
  task automatic wait_hi(input bit sel, output int c);
    c = 0;
    while (c < 300 && (sel ? lpi_expired_q : sc_expired_q) !== 1'b1)
    begin
      @(negedge clk);
      c++;
    end
    if (c == 300)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic t_regs;
    rd_chk(16'h0400, 16'h09C2);
    rd_chk(16'h0410, 16'h03E8);
    rd_chk(16'h0420, 16'h03E8);
    rd_chk(16'h0430, 16'h0000);
    wr(16'h0400, 16'h0000);
    wr(16'h0410, 16'h0005);
    wr(16'h0420, 16'h0003);
    rd_chk(16'h0400, 16'h0000);
    rd_chk(16'h0410, 16'h0005);
    rd_chk(16'h0420, 16'h0003);
    // clock enable low: the write must be ignored
    ce = 1'b0;
    wr(16'h0420, 16'h0007);
    ce = 1'b1;
    rd_chk(16'h0420, 16'h0003);
    $display("test regs done");
  endtask
  task automatic t_sc;
    int c;
    sc_enable = 1'b1;
    pulse(0);
    `CHK(out_pins_q, 8'hA5);
    wait_hi(0, c);
    `CHK(c >= 41 && c <= 60, 1);
    `CHK(out_pins_q, 8'h3C);
    repeat (100) @(negedge clk);
    `CHK(sc_expired_q, 1'b1);
    pulse(0);
    `CHK(sc_expired_q, 1'b0);
    run_pd = 1'b1;
    repeat (300) @(negedge clk);
    `CHK(sc_expired_q, 1'b0);
    `CHK(out_pins_q, 8'hA5);
    safe_op_state = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(out_pins_q, 8'h3C);
    safe_op_state = 1'b0;
    $display("test sync channel done");
  endtask
  task automatic t_lpi;
    int c;
    safe_use_value = 1'b0;
    lpi_enable = 1'b1;
    pulse(1);
    wait_hi(1, c);
    `CHK(c >= 81 && c <= 100, 1);
    `CHK(out_pins_q, 8'h00);
    run_lpi = 1'b1;
    repeat (300) @(negedge clk);
    `CHK(lpi_expired_q, 1'b0);
    `CHK(out_pins_q, 8'hA5);
    $display("test local interface done");
  endtask
  // an expired dog must drop its flag once its timer is set to zero
  task automatic t_zero;
    int c;
    run_pd = 1'b0;
    wait_hi(0, c);
    `CHK(out_pins_q, 8'h00);
    wr(16'h0420, 16'h0000);
    repeat (300) @(negedge clk);
    `CHK(sc_expired_q, 1'b0);
    `CHK(out_pins_q, 8'hA5);
    $display("test zero timer done");
  endtask
  // mid-run reset brings the defaults back
  task automatic t_rst;
    @(negedge clk);
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    rd_chk(16'h0420, 16'h03E8);
    rd_chk(16'h0400, 16'h09C2);
    `CHK(sc_expired_q, 1'b0);
    $display("test mid-run reset done");
  endtask
  // reset for 16 cycles, then the scenarios
  initial
  begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_sc();
    t_lpi();
    t_zero();
    t_rst();
    tally_and_finish();
  end
endmodule
